// *** include/rst_seq_pkg.sv ***
/*
 reset sequencer package: register offsets, field positions, fuse encodings,
 timing constants and the sequencer state type.
 assumes an apb slave with 32-bit data and word-aligned registers.
*/
package rst_seq_pkg;
    // registers, byte addresses (printed offsets +0x00/+0x01 are indices)
    localparam logic [7:0] idx_cause_flags = 8'h00;
    localparam logic [7:0] idx_control = 8'h01;
    localparam logic [11:0] addr_cause_flags = 12'h000;
    localparam logic [11:0] addr_control = 12'h004;
    localparam logic [11:0] addr_fuses = 12'h008;
    localparam logic [11:0] addr_state = 12'h00c;

    // cause flag bits
    localparam int bit_por = 0;
    localparam int bit_pin = 1;
    localparam int bit_bod = 2;
    localparam int bit_wdt = 3;
    localparam int bit_dbg = 4;
    localparam int bit_soft = 5;
    localparam int bit_soft_reset_request = 0;
    localparam logic [5:0] flags_reset = 6'h00;

    // startup delay fuse
    localparam logic [1:0] sut_64k = 2'h0;
    localparam logic [1:0] sut_4k = 2'h1;
    localparam logic [1:0] sut_rsvd = 2'h2;
    localparam logic [1:0] sut_none = 2'h3;
    localparam logic [16:0] ticks_64k = 17'h10000;
    localparam logic [16:0] ticks_4k = 17'h01000;
    localparam logic [4:0] sys_cycles = 5'h18;

    // brownout mode fuse
    localparam logic [1:0] bod_rsvd = 2'h0;
    localparam logic [1:0] bod_sampled = 2'h1;
    localparam logic [1:0] bod_enabled = 2'h2;
    localparam logic [1:0] bod_disabled = 2'h3;
    localparam logic [2:0] bod_level_lowest = 3'h7;

    // sleep modes in which active setting applies
    localparam logic [2:0] smode_idle = 3'h0;

    // timing
    localparam int clk_hz = 40000000;
    localparam int ulp_hz = 1000;
    localparam int rc2m_hz = 2000000;
    localparam int ulp_div = clk_hz / ulp_hz;
    localparam int rc2m_div = clk_hz / rc2m_hz;
    localparam logic [4:0] calib_words = 5'h04;

    typedef enum logic [2:0] {
        st_hold = 3'b000,
        st_delay = 3'b001,
        st_sys = 3'b011,
        st_osc = 3'b010,
        st_calib = 3'b110,
        st_run = 3'b111
    } seq_state_t;
endpackage

// *** hdl/req_sync.sv ***
/*
 two-flop synchroniser for a level request.
 assumes input comes from outside the clk domain.
*/
`timescale 1ns/1ps
module req_sync #(
    parameter logic idle_level = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_t;
    sync_t r_ff;
    sync_t nxt_r;

    always_comb
    begin
        nxt_r.s1 = d;
        nxt_r.s2 = r_ff.s1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            r_ff <= {2{idle_level}};
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign q = r_ff.s2;
endmodule

// *** hdl/reset_sequencer.sv ***
/*
 reset sequencer: merges six reset sources, runs the post-release delay,
 oscillator start and calibration load, and holds cause flags and the
 software reset bit behind an apb slave.
 assumes detectors, pin and debug port are asynchronous levels; the
 protection unlock is decoded outside and given as cfg_unlock.
*/
// Function
// - any request resets at once; reset held while any request stays high
// - after release: counter delay, oscillator startup, calibration, then run
// - a new request during the stages restarts the whole sequence
// - delay counted in 1khz ticks, then 24 system clocks
// - fuse 00 64k ticks, 01 4k ticks, 10 reserved, 11 only 24 clocks
// - every reset resets clock system and selects the 2mhz oscillator
// - after delay start 2mhz oscillator and copy calibration row to registers
// - power-on detect starts sequence and holds reset while supply is low
// - brownout mode 00 reserved, 01 sampled, 10 enabled, 11 disabled
// - active and idle use active setting, other sleep modes sleep setting
// - sampled mode powers detector once per tick; detection forces continuous
// - disabled detector forced on at lowest level in erase or debug enable
// - brownout reset immediate; release goes through counter timeout
// - threshold change takes effect only on leaving programming mode
// - pin reset held while pin stays low
// - watchdog reset lasts one to two 2mhz oscillator cycles; here the request lasts while wdt_timeout stays high
// - software reset bit issues reset within two clocks, no instruction between
// - debug-port reset is its own source, only from the external debugger
// - flags bit5 soft, 4 debug, 3 watchdog, 2 brownout, 1 pin; clear by por or w1
// - power-on flag bit 0 set on por, cleared only by writing one
// - software reset bit clears automatically when reset issues
// - execution starts at reset vector: zero or boot section start
`timescale 1ns/1ps
module reset_sequencer #(
    parameter int delay_64k_ticks = 65536,
    parameter int delay_4k_ticks = 4096,
    parameter int ulp_div_cycles = rst_seq_pkg::ulp_div
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic por_det,
    input wire logic bod_det,
    input wire logic reset_pin_n,
    input wire logic wdt_timeout,
    input wire logic dbg_reset_req,
    input wire logic dbg_port_enabled,
    input wire logic chip_erase,
    input wire logic prog_mode,
    input wire logic cpu_sleeping,
    input wire logic [2:0] sleep_mode,
    input wire logic [1:0] startup_delay_fuse,
    input wire logic [1:0] brownout_active_mode_setting,
    input wire logic [1:0] brownout_sleep_mode_setting,
    input wire logic [2:0] brownout_threshold_select,
    input wire logic boot_reset_vector,
    input wire logic [15:0] boot_section_start,
    input wire logic [7:0] calib_row_data,
    input wire logic cfg_unlock,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic sys_reset,
    output logic clk_sys_reset,
    output logic rc2m_select,
    output logic rc2m_enable,
    output logic [1:0] calib_addr,
    output logic calib_we,
    output logic [7:0] calib_wdata,
    output logic bod_power,
    output logic [2:0] bod_level,
    output logic [15:0] reset_vector
);
    logic s_por;
    logic s_bod;
    logic s_pin_n;
    logic s_wdt;
    logic s_dbg;

    // every asynchronous source passes two flops before use
    req_sync u_por (.clk(clk), .reset(reset), .d(por_det), .q(s_por));
    req_sync u_bod (.clk(clk), .reset(reset), .d(bod_det), .q(s_bod));
    // pin idles high: a cleared flop would fake a pin reset after reset
    req_sync #(.idle_level(1'b1)) u_pin (.clk(clk), .reset(reset), .d(reset_pin_n), .q(s_pin_n));
    req_sync u_wdt (.clk(clk), .reset(reset), .d(wdt_timeout), .q(s_wdt));
    req_sync u_dbg (.clk(clk), .reset(reset), .d(dbg_reset_req), .q(s_dbg));

    typedef struct packed {
        rst_seq_pkg::seq_state_t st;
        logic [16:0] ticks;
        logic [4:0] sys_cnt;
        logic [15:0] ulp_cnt;
        logic [4:0] rc_cnt;
        logic rc_phase;
        logic [5:0] flags;
        logic soft_reset_request;
        logic [1:0] sw_cnt;
        logic bod_latched;
        logic bod_cont;
        logic [2:0] bod_lvl;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic sys_reset;
        logic rc2m_en;
        logic [1:0] cal_addr;
        logic cal_we;
        logic [7:0] cal_wdata;
        logic bod_pwr;
        logic [15:0] vector;
    } state_t;

    state_t r_ff;
    state_t nxt_r;

    logic [1:0] bod_mode;
    logic bod_on;
    logic tick;
    logic req_any;
    logic bod_req;
    logic sw_fire;
    logic wr_ok;
    logic rd_ok;
    logic [16:0] delay_ticks;

    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.pready = 1'b0;
        nxt_r.pslverr = 1'b0;
        nxt_r.cal_we = 1'b0;
        nxt_r.bod_pwr = 1'b0;

        // 1khz tick divider
        tick = 1'b0;
        if (r_ff.ulp_cnt == 16'(ulp_div_cycles - 1))
        begin
            nxt_r.ulp_cnt = '0;
            tick = 1'b1;
        end
        else
        begin
            nxt_r.ulp_cnt = r_ff.ulp_cnt + 16'h0001;
        end

        // brownout mode select
        if (!cpu_sleeping || sleep_mode == rst_seq_pkg::smode_idle)
        begin
            bod_mode = brownout_active_mode_setting;
        end
        else
        begin
            bod_mode = brownout_sleep_mode_setting;
        end
        bod_on = 1'b0;
        case (bod_mode)
            rst_seq_pkg::bod_sampled:
            begin
                nxt_r.bod_pwr = tick || r_ff.bod_cont;
                bod_on = 1'b1;
            end
            rst_seq_pkg::bod_enabled:
            begin
                nxt_r.bod_pwr = 1'b1;
                bod_on = 1'b1;
            end
            default:
            begin
                // disabled or reserved: off unless forced
                if (chip_erase || dbg_port_enabled)
                begin
                    nxt_r.bod_pwr = 1'b1;
                    bod_on = 1'b1;
                end
            end
        endcase
        // sampled mode only sees a drop at a sample; detection holds it on
        nxt_r.bod_latched = s_bod && bod_on && (r_ff.bod_pwr || r_ff.bod_cont);
        if (nxt_r.bod_latched && bod_mode == rst_seq_pkg::bod_sampled)
        begin
            nxt_r.bod_cont = 1'b1;
        end
        else if (!s_bod)
        begin
            nxt_r.bod_cont = 1'b0;
        end
        bod_req = r_ff.bod_latched;
        if (chip_erase || dbg_port_enabled)
        begin
            if (bod_mode == rst_seq_pkg::bod_disabled || bod_mode == rst_seq_pkg::bod_rsvd)
            begin
                nxt_r.bod_lvl = rst_seq_pkg::bod_level_lowest;
            end
        end
        else if (!prog_mode)
        begin
            nxt_r.bod_lvl = brownout_threshold_select;
        end

        // software reset: two-cycle issue window
        sw_fire = r_ff.soft_reset_request && r_ff.sw_cnt != 2'h0;

        req_any = s_por || bod_req || !s_pin_n || s_wdt || s_dbg || sw_fire;

        case (startup_delay_fuse)
            rst_seq_pkg::sut_64k: delay_ticks = 17'(delay_64k_ticks);
            rst_seq_pkg::sut_4k: delay_ticks = 17'(delay_4k_ticks);
            default: delay_ticks = '0;
        endcase

        // sequencer
        if (req_any)
        begin
            nxt_r.st = rst_seq_pkg::st_hold;
            nxt_r.sys_reset = 1'b1;
            nxt_r.rc2m_en = 1'b0;
            nxt_r.ticks = '0;
            nxt_r.sys_cnt = '0;
            nxt_r.cal_addr = '0;
        end
        else
        begin
            case (r_ff.st)
                rst_seq_pkg::st_hold:
                begin
                    nxt_r.st = rst_seq_pkg::st_delay;
                    nxt_r.ticks = '0;
                end
                rst_seq_pkg::st_delay:
                begin
                    if (r_ff.ticks >= delay_ticks)
                    begin
                        nxt_r.st = rst_seq_pkg::st_sys;
                        nxt_r.sys_cnt = '0;
                    end
                    else if (tick)
                    begin
                        nxt_r.ticks = r_ff.ticks + 17'h00001;
                    end
                end
                rst_seq_pkg::st_sys:
                begin
                    if (r_ff.sys_cnt == rst_seq_pkg::sys_cycles - 5'h01)
                    begin
                        nxt_r.st = rst_seq_pkg::st_osc;
                    end
                    else
                    begin
                        nxt_r.sys_cnt = r_ff.sys_cnt + 5'h01;
                    end
                end
                rst_seq_pkg::st_osc:
                begin
                    nxt_r.rc2m_en = 1'b1;
                    nxt_r.st = rst_seq_pkg::st_calib;
                    nxt_r.cal_addr = '0;
                end
                rst_seq_pkg::st_calib:
                begin
                    // two clocks per word: row data follows the registered address
                    if (!r_ff.cal_we)
                    begin
                        nxt_r.cal_we = 1'b1;
                        nxt_r.cal_wdata = calib_row_data;
                    end
                    else if (r_ff.cal_addr == 2'(rst_seq_pkg::calib_words - 5'h01))
                    begin
                        nxt_r.st = rst_seq_pkg::st_run;
                        nxt_r.sys_reset = 1'b0;
                    end
                    else
                    begin
                        nxt_r.cal_addr = r_ff.cal_addr + 2'h1;
                    end
                end
                rst_seq_pkg::st_run:
                begin
                    nxt_r.sys_reset = 1'b0;
                end
                default:
                begin
                    nxt_r.st = rst_seq_pkg::st_hold;
                end
            endcase
        end

        // reset vector chosen at each reset
        if (r_ff.sys_reset)
        begin
            nxt_r.vector = boot_reset_vector ? boot_section_start : 16'h0000;
        end

        // 2mhz count: rc_phase toggles once per 2mhz cycle (20 clocks); nothing reads it
        if (r_ff.rc_cnt == 5'(rst_seq_pkg::rc2m_div - 1))
        begin
            nxt_r.rc_cnt = '0;
            nxt_r.rc_phase = !r_ff.rc_phase;
        end
        else
        begin
            nxt_r.rc_cnt = r_ff.rc_cnt + 5'h01;
        end

        // apb
        wr_ok = psel && penable && pwrite && !r_ff.pready;
        rd_ok = psel && penable && !pwrite && !r_ff.pready;
        if (psel && penable && !r_ff.pready)
        begin
            nxt_r.pready = 1'b1;
            nxt_r.prdata = '0;
            case (paddr)
                rst_seq_pkg::addr_cause_flags: nxt_r.prdata = {26'h0, r_ff.flags};
                rst_seq_pkg::addr_control: nxt_r.prdata = {31'h0, r_ff.soft_reset_request};
                rst_seq_pkg::addr_fuses: nxt_r.prdata = {24'h0, r_ff.bod_lvl, bod_mode, startup_delay_fuse, r_ff.bod_pwr};
                rst_seq_pkg::addr_state: nxt_r.prdata = {29'h0, r_ff.st};
                default: nxt_r.pslverr = 1'b1;
            endcase
            if (!rd_ok)
            begin
                nxt_r.prdata = '0;
            end
        end

        // software reset bit
        if (r_ff.soft_reset_request)
        begin
            nxt_r.sw_cnt = r_ff.sw_cnt + 2'h1;
            if (r_ff.sw_cnt == 2'h2 || (r_ff.sys_reset && r_ff.sw_cnt != 2'h0))
            begin
                nxt_r.soft_reset_request = 1'b0;
                nxt_r.sw_cnt = '0;
            end
        end
        if (wr_ok && paddr == rst_seq_pkg::addr_control && cfg_unlock)
        begin
            if (pwdata[rst_seq_pkg::bit_soft_reset_request])
            begin
                nxt_r.soft_reset_request = 1'b1;
                nxt_r.sw_cnt = 2'h1;
            end
        end

        // cause flags: write one to clear, set wins
        if (wr_ok && paddr == rst_seq_pkg::addr_cause_flags)
        begin
            nxt_r.flags = r_ff.flags & ~pwdata[5:0];
        end
        if (s_por)
        begin
            nxt_r.flags = rst_seq_pkg::flags_reset;
            nxt_r.flags[rst_seq_pkg::bit_por] = 1'b1;
        end
        else
        begin
            if (!s_pin_n) nxt_r.flags[rst_seq_pkg::bit_pin] = 1'b1;
            if (bod_req) nxt_r.flags[rst_seq_pkg::bit_bod] = 1'b1;
            if (s_wdt) nxt_r.flags[rst_seq_pkg::bit_wdt] = 1'b1;
            if (s_dbg) nxt_r.flags[rst_seq_pkg::bit_dbg] = 1'b1;
            if (sw_fire) nxt_r.flags[rst_seq_pkg::bit_soft] = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            r_ff <= '0;
            r_ff.sys_reset <= 1'b1;
            r_ff.flags <= 6'h01;
            r_ff.bod_lvl <= rst_seq_pkg::bod_level_lowest;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign prdata = r_ff.prdata;
    assign pready = r_ff.pready;
    assign pslverr = r_ff.pslverr;
    assign sys_reset = r_ff.sys_reset;
    assign clk_sys_reset = r_ff.sys_reset;
    assign rc2m_select = r_ff.sys_reset;
    assign rc2m_enable = r_ff.rc2m_en;
    assign calib_addr = r_ff.cal_addr;
    assign calib_we = r_ff.cal_we;
    assign calib_wdata = r_ff.cal_wdata;
    assign bod_power = r_ff.bod_pwr;
    assign bod_level = r_ff.bod_lvl;
    assign reset_vector = r_ff.vector;
endmodule

// *** tb/reset_sequencer_asserts.sv ***
/*
 port checker for reset_sequencer.
 assumes it is bound to the sequencer; sees its ports only.
*/
`timescale 1ns/1ps
module reset_sequencer_asserts (
    input wire logic clk,
    input wire logic reset,
    input wire logic por_det,
    input wire logic reset_pin_n,
    input wire logic chip_erase,
    input wire logic cpu_sleeping,
    input wire logic [1:0] brownout_active_mode_setting,
    input wire logic cfg_unlock,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic sys_reset,
    input wire logic rc2m_select,
    input wire logic calib_we,
    input wire logic bod_power,
    input wire logic [2:0] bod_level,
    input wire logic boot_reset_vector,
    input wire logic [15:0] boot_section_start,
    input wire logic [15:0] reset_vector
);
    logic [2:0] cal_cnt_ff;
    logic [5:0] hold_cnt_ff;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // counts calibration words and cycles spent in reset since reset rose
    always_ff @(posedge clk)
    begin
        if (reset || !sys_reset)
            cal_cnt_ff <= 3'h0;
        else if (calib_we)
            cal_cnt_ff <= cal_cnt_ff + 3'h1;
        if (reset || !sys_reset)
            hold_cnt_ff <= 6'h00;
        else if (hold_cnt_ff != 6'h3f)
            hold_cnt_ff <= hold_cnt_ff + 6'h01;
    end
    // two sync flops plus the request register: four cycles is enough
    a_power_holds: assert property (por_det [*4] |-> sys_reset)
        else $error("power-on request without reset");
    a_pin_holds: assert property (!reset_pin_n [*4] |-> sys_reset)
        else $error("pin low without reset");
    a_calib_words: assert property ($fell(sys_reset) |-> cal_cnt_ff == 3'h4)
        else $error("release without four calibration words");
    a_hold_long: assert property ($fell(sys_reset) |-> hold_cnt_ff >= 6'h22)
        else $error("reset released too early");
    a_osc_select: assert property (sys_reset |-> rc2m_select)
        else $error("oscillator not selected in reset");
    a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("bus answer not one cycle after access");
    a_soft_reset: assert property (psel && penable && pready && pwrite && cfg_unlock && pwdata[0]
        && paddr == rst_seq_pkg::addr_control |-> ##[1:3] sys_reset)
        else $error("software reset not issued in time");
    a_forced_on: assert property ((chip_erase && !cpu_sleeping && brownout_active_mode_setting == 2'h3) [*3]
        |-> bod_power && bod_level == 3'h7)
        else $error("detector not forced on in erase");
    a_vector_sel: assert property ($fell(sys_reset)
        |-> reset_vector == (boot_reset_vector ? boot_section_start : 16'h0000))
        else $error("wrong reset vector at release");
endmodule
bind reset_sequencer reset_sequencer_asserts i_reset_sequencer_asserts (.clk, .reset, .por_det, .reset_pin_n,
    .chip_erase, .cpu_sleeping, .brownout_active_mode_setting, .cfg_unlock, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .sys_reset, .rc2m_select, .calib_we, .bod_power, .bod_level, .boot_reset_vector,
    .boot_section_start, .reset_vector);

// *** tb/calib_row_model.sv ***
/*
 calibration row and the oscillator calibration registers it feeds.
 assumes address, strobe and data come straight from the sequencer.
*/
`timescale 1ns/1ps
module calib_row_model (
    input wire logic clk,
    input wire logic [1:0] calib_addr,
    input wire logic calib_we,
    input wire logic [7:0] calib_wdata,
    output logic [7:0] calib_row_data
);
    logic [7:0] cal_regs [4];
    // distinct word per address so a swapped address shows up
    assign calib_row_data = 8'ha0 + {6'h00, calib_addr};
    initial
        foreach (cal_regs[i]) cal_regs[i] = 8'h00;
    always @(posedge clk)
        if (calib_we)
            cal_regs[calib_addr] <= calib_wdata;
endmodule

// *** tb/tb.sv ***
/*
 self-checking bench for reset_sequencer with the calibration row model.
 assumes shortened delays: 8 and 4 ticks of 10 clocks.
*/
`timescale 1ns/1ps
module tb;
    localparam int tk = 10;
    logic clk = 1'b0, reset = 1'b1, por_det = 1'b0, bod_det = 1'b0, reset_pin_n = 1'b1;
    logic wdt_timeout = 1'b0, dbg_reset_req = 1'b0, dbg_port_enabled = 1'b0, chip_erase = 1'b0;
    logic cpu_sleeping = 1'b0, boot_reset_vector = 1'b0, cfg_unlock = 1'b0, rc2m_enable;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, sys_reset, rc2m_select, calib_we, bod_power;
    logic [1:0] startup_delay_fuse = 2'h3, brownout_active_mode_setting = 2'h2, calib_addr;
    logic [15:0] boot_section_start = 16'h0000, reset_vector;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [7:0] calib_wdata, calib_row_data;
    logic [2:0] bod_level, brownout_threshold_select = 3'h2;
    int mismatches = 0, check_count = 0;
    always #12.5 clk = ~clk;
    reset_sequencer #(.delay_64k_ticks(8), .delay_4k_ticks(4), .ulp_div_cycles(tk)) i_reset_sequencer (
        .clk, .reset, .por_det, .bod_det, .reset_pin_n, .wdt_timeout, .dbg_reset_req, .dbg_port_enabled,
        .chip_erase, .prog_mode(1'b0), .cpu_sleeping, .sleep_mode(3'h0), .startup_delay_fuse,
        .brownout_active_mode_setting, .brownout_sleep_mode_setting(2'h3), .brownout_threshold_select,
        .boot_reset_vector, .boot_section_start, .calib_row_data, .cfg_unlock, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .sys_reset, .clk_sys_reset(), .rc2m_select, .rc2m_enable,
        .calib_addr, .calib_we, .calib_wdata, .bod_power, .bod_level, .reset_vector);
    calib_row_model i_calib_row_model (.clk, .calib_addr, .calib_we, .calib_wdata, .calib_row_data);
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input int v);
        check_count++;
        if (v < lo || v > hi)
        begin
            mismatches++;
            $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, v);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // entered just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                       output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // answer taken at the rising edge; only the watchdog ends a hung wait
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic e;
        apb(1'b0, a, 32'h0, rd, e);
        chk(nm, exp, rd);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, d, rd, e);
    endtask
    // cycles from the call until the device is seen running
    task automatic wait_run(output int n);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (sys_reset !== 1'b0 && n < 400);
        @(posedge clk);
    endtask
    task automatic drive_src(input int s, input logic on);
        case (s)
            0: por_det <= on;
            1: reset_pin_n <= !on;
            2: bod_det <= on;
            3: wdt_timeout <= on;
            default: dbg_reset_req <= on;
        endcase
    endtask
    task automatic src_case(input int s, input int b, input logic clr);
        int n;
        drive_src(s, 1'b1);
        cyc(20);
        drive_src(s, 1'b0);
        wait_run(n);
        chk_rng("release cycles", 34, 50, n);
        rd_chk("cause flags", rst_seq_pkg::addr_cause_flags, 32'h1 << b);
        if (clr)
            wr(rst_seq_pkg::addr_cause_flags, 32'h1 << b);
    endtask
    task automatic bod_mode(input logic [1:0] m, input logic exp);
        int n;
        brownout_active_mode_setting <= m;
        drive_src(2, 1'b1);
        cyc(30);
        @(negedge clk);
        chk("reset in brownout", {31'h0, exp}, {31'h0, sys_reset});
        chk("oscillator in reset", {31'h0, !exp}, {31'h0, rc2m_enable});
        @(posedge clk);
        drive_src(2, 1'b0);
        if (exp)
            wait_run(n);
    endtask
    task automatic fuse_case(input logic [1:0] f, input int t);
        int n;
        startup_delay_fuse <= f;
        drive_src(1, 1'b1);
        cyc(4);
        drive_src(1, 1'b0);
        wait_run(n);
        chk_rng("startup delay", 34 + tk * t - (t > 0 ? tk : 0), 50 + tk * t, n);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
    initial
    begin
        int n;
        logic [31:0] rd;
        logic e;
        cyc(16);
        reset <= 1'b0;
        wait_run(n);
        for (int i = 0; i < 4; i++)
            chk("calibration word", 32'ha0 + i, {24'h0, i_calib_row_model.cal_regs[i]});
        chk("reset vector", 32'h0, {16'h0, reset_vector});
        chk("oscillator enable", 32'h1, {31'h0, rc2m_enable});
        rd_chk("flags at power up", rst_seq_pkg::addr_cause_flags, 32'h01);
        wr(rst_seq_pkg::addr_cause_flags, 32'h1);
        rd_chk("flags after clear", rst_seq_pkg::addr_cause_flags, 32'h00);
        src_case(1, 1, 1'b1);
        src_case(2, 2, 1'b1);
        src_case(3, 3, 1'b1);
        src_case(4, 4, 1'b0);
        src_case(0, 0, 1'b1);
        bod_mode(2'h1, 1'b1);
        bod_mode(2'h3, 1'b0);
        wr(rst_seq_pkg::addr_cause_flags, 32'h3f);
        wr(rst_seq_pkg::addr_control, 32'h1);
        cyc(6);
        @(negedge clk);
        chk("reset after locked write", 32'h0, {31'h0, sys_reset});
        @(posedge clk);
        cfg_unlock <= 1'b1;
        wr(rst_seq_pkg::addr_control, 32'h1);
        cfg_unlock <= 1'b0;
        wait_run(n);
        rd_chk("flags after soft reset", rst_seq_pkg::addr_cause_flags, 32'h20);
        rd_chk("control after soft reset", rst_seq_pkg::addr_control, 32'h0);
        startup_delay_fuse <= 2'h1;
        drive_src(1, 1'b1);
        cyc(4);
        drive_src(1, 1'b0);
        cyc(25);
        drive_src(3, 1'b1);
        cyc(20);
        drive_src(3, 1'b0);
        wait_run(n);
        chk_rng("cycles after restart", 64, 90, n);
        fuse_case(2'h0, 8);
        fuse_case(2'h1, 4);
        fuse_case(2'h2, 0);
        boot_reset_vector <= 1'b1;
        boot_section_start <= 16'h4000;
        fuse_case(2'h3, 0);
        @(negedge clk);
        chk("boot reset vector", 32'h4000, {16'h0, reset_vector});
        @(posedge clk);
        apb(1'b0, 12'h010, 32'h0, rd, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, rd);
        brownout_active_mode_setting <= 2'h3;
        for (int i = 0; i < 2; i++)
        begin
            chip_erase <= (i == 0);
            dbg_port_enabled <= (i == 1);
            cyc(4);
            @(negedge clk);
            chk("detector power", 32'h1, {31'h0, bod_power});
            chk("detector level", 32'h7, {29'h0, bod_level});
            @(posedge clk);
        end
        chip_erase <= 1'b0;
        dbg_port_enabled <= 1'b0;
        cyc(4);
        @(negedge clk);
        chk("detector off", 32'h0, {31'h0, bod_power});
        chk("selected level", 32'h2, {29'h0, bod_level});
        @(posedge clk);
        end_of_test();
    end
endmodule
